// file: bench/crc_regs_sva.sv
`timescale 1ns/1ns
module crc_regs_sva (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [3:0]   pstrb,
    input wire logic         pslverr,
    input wire logic [31:0]  prdata,
    input wire logic         port_direction,
    input crc_pkg::crc_vref_s reference_config,
    input wire logic         ladder_on,
    input wire logic         reference_pin_drive,
    input wire logic         reference_pin_input_mode
);
    wire        acc   = psel && penable;
    wire        vr_wr = acc && pwrite && paddr == crc_pkg::OFS_VREF;
    wire        cc_wr = acc && pwrite && paddr == crc_pkg::OFS_CONTROL;
    wire        vr_rd = acc && !pwrite && paddr == crc_pkg::OFS_VREF;
    wire [11:0] rc    = reference_config;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ladder_on: assert property (ladder_on == rc[7])
        else $error("ladder enable wrong");
    chk_pin_route: assert property (reference_pin_drive == rc[6])
        else $error("pin routing wrong");
    chk_dir_override: assert property (reference_pin_input_mode ==
        (reference_pin_drive ? 1'b0 : port_direction))
        else $error("pin direction wrong");
    chk_vref_layout: assert property (vr_wr && pstrb[1:0] == 2'b11 |=>
        rc == {$past(pwdata[14]), $past(pwdata[10:0])}) else $error("bad layout");
    chk_read_back: assert property (vr_rd |-> prdata == {17'h0,
        rc[11], 3'h0, rc[10:0]}) else $error("read back wrong");
    chk_upper_zero:
        assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper half set");
    chk_unmapped_err: assert property (acc && paddr > 8'h14 |->
        pslverr && prdata == 32'h0) else $error("unmapped access wrong");
    chk_cfg_hold: assert property ($changed(rc) |-> $past(vr_wr))
        else $error("config moved");
    chk_cmp_indep: assert property (cc_wr |=> $stable(rc))
        else $error("config followed comparator");
endmodule
bind crc_regs crc_regs_sva i_chk (.*);

// file: bench/crc_regs_tb.sv
`timescale 1ns/1ns
module crc_regs_tb;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic               penable = 1'b0, pwrite = 1'b0, sleep_wake = 1'b0;
    logic               port_direction = 1'b1, pready, pslverr, err;
    logic               ladder_on, reference_pin_drive, comparator_enable;
    logic               reference_pin_input_mode;
    logic [7:0]         paddr = 8'h00;
    logic [3:0]         pstrb = 4'hF;
    logic [31:0]        pwdata = 32'h0, prdata, rd;
    logic [15:0]        mk [6];
    crc_pkg::crc_vref_s reference_config;
    int                 err_total = 0, compares = 0;
    crc_regs i_dut (.*);
    initial forever #4 pclk = ~pclk;
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d, compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        mk = '{crc_pkg::MASK_STATUS, crc_pkg::MASK_CONTROL, crc_pkg::MASK_BLANK_SRC,
            crc_pkg::MASK_BLANK_GATE, crc_pkg::MASK_FILTER, crc_pkg::MASK_VREF};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF);
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, {16'h0, mk[i]});
        end
        apb(1'b1, crc_pkg::OFS_VREF, 32'h0000_00CA);
        chk(32'(reference_config), 32'h0CA);
        chk(32'({ladder_on, reference_pin_drive, reference_pin_input_mode}), 32'h6);
        apb(1'b1, crc_pkg::OFS_VREF, 32'h0000_0025);
        chk(32'({ladder_on, reference_pin_drive, reference_pin_input_mode}), 32'h1);
        port_direction <= 1'b0;
        @(posedge pclk);
        chk(32'(reference_pin_input_mode), 32'h0);
        // Wake must not touch the stored setup
        sleep_wake <= 1'b1;
        repeat (3) @(posedge pclk);
        sleep_wake <= 1'b0;
        @(posedge pclk);
        chk(32'(reference_config), 32'h025);
        apb(1'b1, crc_pkg::OFS_CONTROL, 32'h0000_8000);
        chk(32'({comparator_enable, ladder_on}), 32'h2);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, crc_pkg::OFS_VREF, 32'h0000_00EF);
        presetn <= 1'b0;
        @(posedge pclk);
        chk(32'(reference_config), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, crc_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule

// file: src/crc_pkg.sv
package crc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS    = 8'h00;
    localparam logic [7:0] OFS_CONTROL   = 8'h04;
    localparam logic [7:0] OFS_BLANK_SRC = 8'h08;
    localparam logic [7:0] OFS_BLANK_GATE = 8'h0C;
    localparam logic [7:0] OFS_FILTER    = 8'h10;
    localparam logic [7:0] OFS_VREF      = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Implemented-bit masks; the rest read zero
    localparam logic [15:0] MASK_STATUS    = 16'h800F;
    localparam logic [15:0] MASK_CONTROL   = 16'hFCF3;
    localparam logic [15:0] MASK_BLANK_SRC = 16'h0FFF;
    localparam logic [15:0] MASK_BLANK_GATE = 16'hBFFF;
    localparam logic [15:0] MASK_FILTER    = 16'h007F;
    localparam logic [15:0] MASK_VREF      = 16'h47FF;

    // Reset value, common to all six registers
    localparam logic [15:0] RST_VALUE = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Reference control field positions
    localparam int VR_OE2_BIT   = 14;
    localparam int VR_SRC_BIT   = 10;
    localparam int VR_BG_LSB    = 8;
    localparam int VR_EN_BIT    = 7;
    localparam int VR_OE_BIT    = 6;
    localparam int VR_RANGE_BIT = 5;
    localparam int VR_SUPPLY_BIT = 4;
    localparam int VR_TAP_LSB   = 0;

    // Comparator control: enable bit
    localparam int CC_EN_BIT = 15;

    typedef struct packed {
        logic       second_reference_output_enable;
        logic       reference_source_select;
        logic [1:0] band_gap_select;
        logic       reference_enable;
        logic       reference_pin_output_enable;
        logic       ladder_range_select;
        logic       reference_supply_source_select;
        logic [3:0] ladder_tap_select;
    } crc_vref_s;

endpackage

// file: src/crc_regs.sv
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module crc_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        sleep_wake,
    input  wire logic        port_direction,
    output crc_pkg::crc_vref_s reference_config,
    output logic             ladder_on,
    output logic             reference_pin_drive,
    output logic             reference_pin_input_mode,
    output logic             comparator_enable
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] status_reg, status_next;
    logic [15:0] control_reg, control_next;
    logic [15:0] bsrc_reg, bsrc_next;
    logic [15:0] bgate_reg, bgate_next;
    logic [15:0] filter_reg, filter_next;
    logic [15:0] vref_reg, vref_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [15:0] rd_word;

    // Merge bus data into a register honouring byte strobes and the mask
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st,
                                          input logic [15:0] msk);
        logic [15:0] v;
        v = old;
        if (st[0]) begin
            v[7:0] = wd[7:0];
        end
        if (st[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & msk;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Zero wait states: access phase always completes in one cycle
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    // Read word is loaded in the setup cycle so it stands in the access cycle
    assign rd_en   = psel & ~penable & ~pwrite;

    always_comb begin
        hit     = 1'b1;
        rd_word = 16'h0000;
        case (paddr)
            crc_pkg::OFS_STATUS:     rd_word = status_reg;
            crc_pkg::OFS_CONTROL:    rd_word = control_reg;
            crc_pkg::OFS_BLANK_SRC:  rd_word = bsrc_reg;
            crc_pkg::OFS_BLANK_GATE: rd_word = bgate_reg;
            crc_pkg::OFS_FILTER:     rd_word = filter_reg;
            crc_pkg::OFS_VREF:       rd_word = vref_reg;
            default:                 hit = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error and read zero
    assign pslverr = psel & penable & ~hit;

    always_comb begin
        status_next  = status_reg;
        control_next = control_reg;
        bsrc_next    = bsrc_reg;
        bgate_next   = bgate_reg;
        filter_next  = filter_reg;
        vref_next    = vref_reg;
        prdata_next  = 32'h0000_0000;
        if (rd_en && hit) begin
            prdata_next = {16'h0000, rd_word};
        end
        if (wr_en) begin
            case (paddr)
                crc_pkg::OFS_STATUS: status_next = merge(status_reg,
                    pwdata, pstrb, crc_pkg::MASK_STATUS);
                crc_pkg::OFS_CONTROL: control_next = merge(control_reg,
                    pwdata, pstrb, crc_pkg::MASK_CONTROL);
                crc_pkg::OFS_BLANK_SRC: bsrc_next = merge(bsrc_reg,
                    pwdata, pstrb, crc_pkg::MASK_BLANK_SRC);
                crc_pkg::OFS_BLANK_GATE: bgate_next = merge(bgate_reg,
                    pwdata, pstrb, crc_pkg::MASK_BLANK_GATE);
                crc_pkg::OFS_FILTER: filter_next = merge(filter_reg,
                    pwdata, pstrb, crc_pkg::MASK_FILTER);
                crc_pkg::OFS_VREF: vref_next = merge(vref_reg,
                    pwdata, pstrb, crc_pkg::MASK_VREF);
                default: begin
                end
            endcase
        end
    end

    // Reset clears enable, pin enable, range and tap; wake does not touch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg  <= crc_pkg::RST_VALUE;
            control_reg <= crc_pkg::RST_VALUE;
            bsrc_reg    <= crc_pkg::RST_VALUE;
            bgate_reg   <= crc_pkg::RST_VALUE;
            filter_reg  <= crc_pkg::RST_VALUE;
            vref_reg    <= crc_pkg::RST_VALUE;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            status_reg  <= status_next;
            control_reg <= control_next;
            bsrc_reg    <= bsrc_next;
            bgate_reg   <= bgate_next;
            filter_reg  <= filter_next;
            vref_reg    <= vref_next;
            prdata_reg  <= prdata_next;
        end
    end

    // Read data comes from a flop but is valid while pready is sampled
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Field view; the analog ladder decodes step size from the range bit
    assign reference_config = crc_pkg::crc_vref_s'({
        vref_reg[crc_pkg::VR_OE2_BIT],
        vref_reg[crc_pkg::VR_SRC_BIT],
        vref_reg[crc_pkg::VR_BG_LSB +: 2],
        vref_reg[crc_pkg::VR_EN_BIT],
        vref_reg[crc_pkg::VR_OE_BIT],
        vref_reg[crc_pkg::VR_RANGE_BIT],
        vref_reg[crc_pkg::VR_SUPPLY_BIT],
        vref_reg[crc_pkg::VR_TAP_LSB +: 4]});

    // Ladder power follows only its own enable, never the comparator's
    assign ladder_on = vref_reg[crc_pkg::VR_EN_BIT];
    assign comparator_enable = control_reg[crc_pkg::CC_EN_BIT];

    // Pin drive ignores port direction while output enable is set
    assign reference_pin_drive = vref_reg[crc_pkg::VR_OE_BIT];
    assign reference_pin_input_mode = vref_reg[crc_pkg::VR_OE_BIT]
                                    ? 1'b0 : port_direction;

    // Wake indication has no effect on any register
    logic unused_wake;
    assign unused_wake = sleep_wake;

endmodule
